//--- hdl/jtdp_params.svh
// constants for the test access port and debug event block
`ifndef JTDP_PARAMS_SVH
`define JTDP_PARAMS_SVH
`define JTDP_IR_WIDTH 4
`define JTDP_IR_RESET 4'h1
`define JTDP_CORE_COUNT 4
`define JTDP_CMD_BYPASS 4'hf
`define JTDP_CMD_IDCODE 4'h1
`define JTDP_CMD_DEBUG 4'h8
`define JTDP_DEBUG_DR_WIDTH 8
`endif

//--- hdl/jtdp_pkg.sv
// types for the test access port and debug event block
package jtdp_pkg;
  typedef enum logic [3:0] {
    JTDP_RESET, JTDP_IDLE, JTDP_SEL_DR, JTDP_CAP_DR, JTDP_SH_DR, JTDP_EX1_DR,
    JTDP_PAU_DR, JTDP_EX2_DR, JTDP_UPD_DR, JTDP_SEL_IR, JTDP_CAP_IR, JTDP_SH_IR,
    JTDP_EX1_IR, JTDP_PAU_IR, JTDP_EX2_IR, JTDP_UPD_IR
  } jtdp_state_e;
endpackage

//--- hdl/jtdp_tap.sv
// test access port controller with shared debug event pins
`timescale 1ns/1ps
`include "jtdp_params.svh"
module jtdp_tap #(
  parameter int CORES = `JTDP_CORE_COUNT,
  parameter logic [31:0] ID_CODE = 32'h00000001 // arbitrary value
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // test port pins, asynchronous to mclk_i
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // debug event pins
  input wire logic debug_request_in_i,
  output logic debug_active_out_o,
  // per-core debug links
  output logic [CORES-1:0] core_debug_req_o,
  input wire logic [CORES-1:0] core_in_debug_i,
  // controller state for observation
  output jtdp_pkg::jtdp_state_e tap_state_o
);
  import jtdp_pkg::*;

  // the debug path holds one status bit per core, so it caps the core count
  if (CORES < 1 || CORES > `JTDP_DEBUG_DR_WIDTH)
  begin : gen_core_check
    $error("core count out of range");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [CORES-1:0] csync1;
  logic [CORES-1:0] csync2;
  logic tck_d;
  // first stage is read only by the second stage
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      csync1 <= '0;
      csync2 <= '0;
      tck_d <= 1'b0;
    end
    else
    begin
      sync1 <= {tck_i, tms_i, tdi_i, ~trst_n_i, debug_request_in_i};
      sync2 <= sync1;
      csync1 <= core_in_debug_i;
      csync2 <= csync1;
      tck_d <= sync2[4];
    end
  end

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s;
  logic dbg_req_s;
  logic tck_rise;
  logic tck_fall;
  assign tck_s = sync2[4];
  assign tms_s = sync2[3];
  assign tdi_s = sync2[2];
  assign trst_s = sync2[1];
  assign dbg_req_s = sync2[0];
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // ----------------------------------------
  // controller state machine
  // ----------------------------------------
  jtdp_state_e state;
  jtdp_state_e next_state;
  // test reset bypasses the link clock entirely
  logic trst_any;
  assign trst_any = reset_i | trst_s;

  always_comb
  begin
    next_state = state;
    case (state)
      JTDP_RESET: next_state = tms_s ? JTDP_RESET : JTDP_IDLE;
      JTDP_IDLE: next_state = tms_s ? JTDP_SEL_DR : JTDP_IDLE;
      JTDP_SEL_DR: next_state = tms_s ? JTDP_SEL_IR : JTDP_CAP_DR;
      JTDP_CAP_DR: next_state = tms_s ? JTDP_EX1_DR : JTDP_SH_DR;
      JTDP_SH_DR: next_state = tms_s ? JTDP_EX1_DR : JTDP_SH_DR;
      JTDP_EX1_DR: next_state = tms_s ? JTDP_UPD_DR : JTDP_PAU_DR;
      JTDP_PAU_DR: next_state = tms_s ? JTDP_EX2_DR : JTDP_PAU_DR;
      JTDP_EX2_DR: next_state = tms_s ? JTDP_UPD_DR : JTDP_SH_DR;
      JTDP_UPD_DR: next_state = tms_s ? JTDP_SEL_DR : JTDP_IDLE;
      JTDP_SEL_IR: next_state = tms_s ? JTDP_RESET : JTDP_CAP_IR;
      JTDP_CAP_IR: next_state = tms_s ? JTDP_EX1_IR : JTDP_SH_IR;
      JTDP_SH_IR: next_state = tms_s ? JTDP_EX1_IR : JTDP_SH_IR;
      JTDP_EX1_IR: next_state = tms_s ? JTDP_UPD_IR : JTDP_PAU_IR;
      JTDP_PAU_IR: next_state = tms_s ? JTDP_EX2_IR : JTDP_PAU_IR;
      JTDP_EX2_IR: next_state = tms_s ? JTDP_UPD_IR : JTDP_SH_IR;
      JTDP_UPD_IR: next_state = tms_s ? JTDP_SEL_DR : JTDP_IDLE;
      default: next_state = JTDP_RESET;
    endcase
  end

  // trst is synchronised, so the clear lands on the third mclk edge
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      state <= JTDP_RESET;
    else if (trst_s)
      state <= JTDP_RESET;
    else if (tck_rise)
      state <= next_state;
  end
  assign tap_state_o = state;

  // ----------------------------------------
  // instruction and data registers
  // ----------------------------------------
  logic [`JTDP_IR_WIDTH-1:0] ir_shift;
  logic [`JTDP_IR_WIDTH-1:0] ir;
  logic [31:0] dr_shift;
  logic [`JTDP_DEBUG_DR_WIDTH-1:0] debug_ctl;

  // length of the selected data path
  function automatic logic [5:0] dr_len(input logic [`JTDP_IR_WIDTH-1:0] cmd);
    if (cmd == `JTDP_CMD_IDCODE)
      dr_len = 6'd32;
    else if (cmd == `JTDP_CMD_DEBUG)
      dr_len = 6'(`JTDP_DEBUG_DR_WIDTH);
    else
      dr_len = 6'd1;
  endfunction

  logic [5:0] len;
  assign len = dr_len(ir);

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ir_shift <= '0;
      ir <= `JTDP_IR_RESET;
    end
    else if (trst_s || (tck_rise && state == JTDP_RESET))
      ir <= `JTDP_IR_RESET;
    else if (tck_rise)
    begin
      if (state == JTDP_CAP_IR)
        ir_shift <= `JTDP_IR_WIDTH'h1;
      else if (state == JTDP_SH_IR)
        ir_shift <= {tdi_s, ir_shift[`JTDP_IR_WIDTH-1:1]};
      else if (state == JTDP_UPD_IR)
        ir <= ir_shift;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      dr_shift <= 32'h0;
    else if (tck_rise)
    begin
      if (state == JTDP_CAP_DR)
      begin
        // bypass captures zero so the tester sees a known leading bit
        if (ir == `JTDP_CMD_IDCODE)
          dr_shift <= ID_CODE;
        else if (ir == `JTDP_CMD_DEBUG)
          dr_shift <= 32'(csync2);
        else
          dr_shift <= 32'h0;
      end
      else if (state == JTDP_SH_DR)
      begin
        // shift right, new bit enters at the top of the selected length
        dr_shift <= (dr_shift >> 1) | (32'(tdi_s) << (len - 6'd1));
      end
    end
  end

  // debug control register, written on update of the debug path
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      debug_ctl <= '0;
    else if (trst_s || (tck_rise && state == JTDP_RESET))
      debug_ctl <= '0;
    else if (tck_rise && state == JTDP_UPD_DR && ir == `JTDP_CMD_DEBUG)
      debug_ctl <= dr_shift[`JTDP_DEBUG_DR_WIDTH-1:0];
  end

  // ----------------------------------------
  // serial output on falling edge
  // ----------------------------------------
  logic shifting;
  assign shifting = (state == JTDP_SH_DR) || (state == JTDP_SH_IR);
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (trst_s)
      tdo_oe_o <= 1'b0;
    else if (tck_fall)
    begin
      tdo_oe_o <= shifting;
      tdo_o <= (state == JTDP_SH_IR) ? ir_shift[0] : dr_shift[0];
    end
  end

  // ----------------------------------------
  // debug event pins, shared by all cores
  // ----------------------------------------
  // one request pin fans out to every core
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      core_debug_req_o <= '0;
      debug_active_out_o <= 1'b0;
    end
    else
    begin
      core_debug_req_o <= {CORES{dbg_req_s}} | debug_ctl[CORES-1:0];
      debug_active_out_o <= |csync2;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  tdo_drive_only_a: assert property (@(posedge mclk_i) disable iff (trst_any)
    tdo_oe_o |-> shifting || state == JTDP_EX1_DR || state == JTDP_EX1_IR)
    else $error("data output driven outside shift");
  tdo_fall_only_a: assert property (@(posedge mclk_i) disable iff (trst_any)
    $changed(tdo_o) |-> $past(tck_fall))
    else $error("data output changed off falling edge");
  state_rise_only_a: assert property (@(posedge mclk_i) disable iff (trst_any)
    (state != $past(state)) |-> $past(tck_rise))
    else $error("state moved without clock rise");
  trst_clears_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    trst_s |=> state == JTDP_RESET && !tdo_oe_o)
    else $error("test reset did not clear controller");
  tms_five_a: assert property (@(posedge mclk_i) disable iff (trst_any)
    tck_rise && tms_s && state == JTDP_SEL_IR |=> state == JTDP_RESET)
    else $error("select-ir with mode high missed reset");
  ir_shift_in_a: assert property (@(posedge mclk_i) disable iff (trst_any)
    tck_rise && state == JTDP_SH_IR |=> ir_shift[`JTDP_IR_WIDTH-1] == $past(tdi_s))
    else $error("instruction bit not captured");
  debug_req_a: assert property (@(posedge mclk_i) disable iff (trst_any)
    dbg_req_s |=> &core_debug_req_o)
    else $error("debug request not passed to cores");
  debug_status_a: assert property (@(posedge mclk_i) disable iff (trst_any)
    ##1 debug_active_out_o == $past(|csync2))
    else $error("debug status wrong");
  shared_pin_a: assert property (@(posedge mclk_i) disable iff (trst_any)
    !dbg_req_s && debug_ctl == '0 |=> core_debug_req_o == '0)
    else $error("core request without shared pin");
endmodule

//--- bench/jtdp_probe.sv
// tester probe model driving the test port pins
`timescale 1ns/1ps
module jtdp_probe (
  // system clock and tdo pin
  input wire logic mclk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  // test port pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  // reset low from power-up, test clock stands low between frames
  initial
  begin
    trst_n_o = 1'b0;
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // one test clock period; tdo taken at the rise, a released line reads inverted
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge mclk_i);
    tms_o <= m;
    tdi_o <= d;
    // three edges here plus the opening one keep the period at eight clocks
    repeat (3) @(posedge mclk_i);
    tck_o <= 1'b1;
    q = tdo_oe_i ? tdo_i : ~tdo_i;
    repeat (4) @(posedge mclk_i);
    tck_o <= 1'b0;
  endtask
  // test reset pin level
  task automatic set_trst(input logic v);
    @(posedge mclk_i);
    trst_n_o <= v;
  endtask
  // five ones reach reset from anywhere, then idle
  task automatic go_idle;
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  // idle to shift-dr, or to shift-ir when ir is set
  task automatic to_shift(input logic ir);
    logic q;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  // n bits lsb first, then update and back to idle
  task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q);
    logic b;
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, d[i], b);
      q[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule

//--- bench/test_jtdp_tap.sv
// self-checking bench for the test port and debug event block
`timescale 1ns/1ps
`include "jtdp_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module test_jtdp_tap;
  import jtdp_pkg::*;
  localparam logic [31:0] ID = 32'h5a3c_96e1; // arbitrary value
  logic mclk_i;
  logic reset_i;
  logic debug_request_in_i;
  logic [3:0] core_in_debug_i;
  logic [31:0] q;
  int err_count = 0;
  int compares = 0;
  wire tck, tms, tdi, trst_n, tdo, tdo_oe, act;
  wire [3:0] req;
  jtdp_state_e st;
  jtdp_probe probe (.mclk_i(mclk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  jtdp_tap #(.CORES(4), .ID_CODE(ID)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .debug_request_in_i(debug_request_in_i), .debug_active_out_o(act),
    .core_debug_req_o(req), .core_in_debug_i(core_in_debug_i), .tap_state_o(st));
  // 20 mhz system clock
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // counts, verdict and end of run
  task automatic wrap_up;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // identity read: enable only in shift, value lsb first
  task automatic t_idcode;
    probe.go_idle();
    probe.to_shift(1'b0);
    repeat (5) @(posedge mclk_i);
    `CHK(st, JTDP_SH_DR)
    `CHK(tdo_oe, 1'b1)
    probe.shift(32, 32'h0, q);
    `CHK(q, ID)
    repeat (5) @(posedge mclk_i);
    `CHK(st, JTDP_IDLE)
    `CHK(tdo_oe, 1'b0)
  endtask
  // bypass delays the input by one bit
  task automatic t_bypass;
    probe.to_shift(1'b1);
    probe.shift(4, `JTDP_CMD_BYPASS, q);
    probe.to_shift(1'b0);
    probe.shift(8, 32'hb5, q);
    `CHK(q[7:1], 7'h35)
    `CHK(q[0], 1'b0)
  endtask
  // shared request pin, shared status pin, debug register
  task automatic t_debug;
    debug_request_in_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    `CHK(req, 4'hf)
    debug_request_in_i <= 1'b0;
    core_in_debug_i <= 4'h4;
    repeat (6) @(posedge mclk_i);
    `CHK(act, 1'b1)
    `CHK(req, 4'h0)
    core_in_debug_i <= 4'h0;
    repeat (6) @(posedge mclk_i);
    `CHK(act, 1'b0)
    core_in_debug_i <= 4'ha;
    probe.to_shift(1'b1);
    probe.shift(4, `JTDP_CMD_DEBUG, q);
    probe.to_shift(1'b0);
    probe.shift(8, 32'h05, q);
    `CHK(q[7:0], 8'h0a)
    repeat (6) @(posedge mclk_i);
    `CHK(req, 4'h5)
  endtask
  // test reset mid-shift acts with no test clock edge
  task automatic t_trst;
    probe.to_shift(1'b1);
    repeat (5) @(posedge mclk_i);
    `CHK(tdo_oe, 1'b1)
    probe.set_trst(1'b0);
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK(st, JTDP_RESET)
    `CHK(tdo_oe, 1'b0)
    probe.set_trst(1'b1);
    probe.go_idle();
    `CHK(req, 4'h0)
  endtask
  // main sequence
  initial
  begin
    reset_i <= 1'b1;
    debug_request_in_i <= 1'b0;
    core_in_debug_i <= 4'h0;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    `CHK(st, JTDP_RESET)
    probe.set_trst(1'b1);
    repeat (3) @(posedge mclk_i);
    t_idcode();
    t_bypass();
    t_debug();
    t_trst();
    wrap_up();
  end
  // run needs about 42 us; over twenty times that means a hang
  initial
  begin
    #1000000;
    err_count++;
    wrap_up();
  end
endmodule
